/* File: amp_core.sv */
// Operand address generation and program counter update sequencer
`timescale 1ns/1ps
`default_nettype none

module amp_core
  import amp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,

  // Decoded instruction request
  input  wire logic        cmd_valid,
  input  wire amp_op_t     cmd_op,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic [14:0] cmd_word,
  input  wire logic [5:0]  cmd_disp,
  input  wire logic [3:0]  cmd_nibble,
  input  wire logic        cmd_ptr_sel,
  input  wire amp_mod_t    cmd_mod,
  input  wire logic [2:0]  cmd_bit,
  output logic             cmd_ready,
  output logic             done,
  output logic             bit_true,

  // Architectural state
  output logic [7:0]       pc_upper_byte,
  output logic [7:0]       pc_lower_byte,
  output logic [7:0]       acc,
  output logic [7:0]       ptr_b,
  output logic [7:0]       ptr_x,
  output logic [7:0]       ptr_sp,

  // Data memory
  output logic [7:0]       dmem_addr,
  output logic             dmem_rd,
  output logic             dmem_wr,
  output logic [7:0]       dmem_wdata,
  output logic             dmem_reg_class,
  input  wire logic [7:0]  dmem_rdata,

  // Program memory
  output logic [14:0]      pmem_addr,
  output logic             pmem_rd,
  input  wire logic [7:0]  pmem_rdata
);

  // All sequencer state
  typedef struct packed {
    amp_state_t  state;      // Sequencer state
    amp_op_t     op;         // Operation in flight
    logic        ptr_sel;    // Pointer in use
    amp_mod_t    mod;        // Its post-modify
    logic [2:0]  bitn;       // Bit number for bit ops
    logic [14:0] pc;         // Program counter
    logic [7:0]  acc;        // Accumulator
    logic        ready;      // Request may be taken
    logic        done;      // Completion pulse
    logic        bit_true;   // Last bit test result

    logic [7:0]  dmem_addr;  // Data address
    logic        dmem_rd;    // Data read strobe
    logic        dmem_wr;    // Data write strobe
    logic [7:0]  dmem_wdata; // Data write value
    logic        reg_class;  // Address lies in register class

    logic [14:0] pmem_addr;  // Program address
    logic        pmem_rd;    // Program read strobe
  } amp_core_st_t;

  amp_core_st_t r;       // Registered state
  amp_core_st_t next_r;  // Next value

  amp_ptr_if ptr ();     // Pointer bank link
  amp_pc_if  pcx ();     // Target arithmetic link

  logic [7:0] rdata;     // Data read, mapped pointers folded in
  logic [7:0] ind_addr;  // Address from the chosen pointer

  // Pointer bank holds the three mapped pointers
  amp_ptr_bank u_ptr (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pif     (ptr.owner)
  );

  // Jump targets and table pointer
  amp_pc_calc u_pc (
    .cif (pcx.calc)
  );

  // Feed the target arithmetic from current state and the request fields
  assign pcx.pc   = r.pc;
  assign pcx.disp = cmd_disp;
  assign pcx.word = cmd_word;
  assign pcx.acc  = r.acc;

  // Pointer-indirect address from first or second pointer
  assign ind_addr = cmd_ptr_sel ? ptr.x : ptr.b;

  // Mapped pointers answer from the bank; everything else from memory
  always_comb begin
    unique case (r.dmem_addr)
      AMP_ADDR_X:  rdata = ptr.x;
      AMP_ADDR_SP: rdata = ptr.sp;
      AMP_ADDR_B:  rdata = ptr.b;
      default:     rdata = dmem_rdata;
    endcase
  end

  // Next-state logic for sequencer, memories and pointer requests
  always_comb begin
    next_r            = r;
    next_r.done       = 1'b0;
    next_r.dmem_rd    = 1'b0;
    next_r.dmem_wr    = 1'b0;
    next_r.pmem_rd    = 1'b0;
    ptr.wr_en         = 1'b0;
    ptr.wr_addr       = r.dmem_addr;
    ptr.wr_data       = 8'h00;
    ptr.short_en      = 1'b0;
    ptr.short_val     = cmd_nibble;
    ptr.mod_en        = 1'b0;
    ptr.mod_sel       = r.ptr_sel;
    ptr.mod_dec       = (r.mod == AMP_MOD_DEC);

    unique case (r.state)
      // Waiting for a request
      AMP_S_IDLE: begin
        if (cmd_valid && r.ready) begin
          next_r.op      = cmd_op;
          next_r.ptr_sel = cmd_ptr_sel;
          next_r.mod     = cmd_mod;
          next_r.bitn    = cmd_bit;
          next_r.ready   = 1'b0;
          unique case (cmd_op)
            // Direct operand: address is the instruction byte
            AMP_OP_LOAD_DIRECT, AMP_OP_SET_BIT, AMP_OP_CLEAR_BIT, AMP_OP_TEST_BIT: begin
              next_r.dmem_addr = cmd_byte;
              next_r.reg_class = (cmd_byte >= AMP_REG_CLASS);
              next_r.dmem_rd   = 1'b1;
              next_r.state     = AMP_S_DREQ;
            end

            // Pointer operand
            AMP_OP_LOAD_POINTER, AMP_OP_XCHG_POINTER: begin
              next_r.dmem_addr = ind_addr;
              next_r.reg_class = (ind_addr >= AMP_REG_CLASS);
              next_r.dmem_rd   = 1'b1;
              next_r.state     = AMP_S_DREQ;
            end

            // Immediate byte follows the opcode
            AMP_OP_LOAD_IMM: begin
              next_r.pmem_addr = pcx.seq1;
              next_r.pmem_rd   = 1'b1;
              next_r.state     = AMP_S_PREQ;
            end

            // Table read or indirect jump through the accumulator
            AMP_OP_TABLE_LOAD, AMP_OP_INDIRECT_JUMP: begin
              next_r.pmem_addr = pcx.tbl;
              next_r.pmem_rd   = 1'b1;
              next_r.state     = AMP_S_PREQ;
            end

            // Short load finishes in the request cycle
            AMP_OP_LOAD_B_SHORT: begin
              ptr.short_en = 1'b1;
              next_r.pc    = pcx.seq1;
              next_r.done  = 1'b1;
              next_r.ready = 1'b1;
            end

            // Relative jump; a field of zero is plus one and simply falls through
            AMP_OP_RELATIVE_JUMP: begin
              next_r.pc    = pcx.rel;
              next_r.done  = 1'b1;
              next_r.ready = 1'b1;
            end

            // Absolute jump stays in its page
            AMP_OP_ABSOLUTE_JUMP: begin
              next_r.pc    = pcx.abs;
              next_r.done  = 1'b1;
              next_r.ready = 1'b1;
            end

            // Long jump takes all fifteen bits
            AMP_OP_LONG_JUMP: begin
              next_r.pc    = cmd_word;
              next_r.done  = 1'b1;
              next_r.ready = 1'b1;
            end

            // No operation and unknown codes step past one byte
            default: begin
              next_r.pc    = pcx.seq1;
              next_r.done  = 1'b1;
              next_r.ready = 1'b1;
            end
          endcase
        end
      end

      // Data strobe is on the pins this cycle
      AMP_S_DREQ: begin
        next_r.state = AMP_S_DGET;
      end

      // Data returned; finish the operation
      AMP_S_DGET: begin
        next_r.state = AMP_S_IDLE;
        next_r.ready = 1'b1;
        next_r.done  = 1'b1;
        unique case (r.op)
          AMP_OP_LOAD_DIRECT: begin
            // Opcode and address byte
            next_r.acc = rdata;
            next_r.pc  = pcx.seq2;
          end

          AMP_OP_LOAD_POINTER: begin
            next_r.acc = rdata;
            next_r.pc  = pcx.seq1;
            ptr.mod_en = (r.mod != AMP_MOD_NONE);
          end

          AMP_OP_XCHG_POINTER: begin
            // Accumulator goes out, memory comes in
            next_r.acc        = rdata;
            next_r.dmem_wr    = 1'b1;
            next_r.dmem_wdata = r.acc;
            ptr.wr_en         = 1'b1;
            ptr.wr_data       = r.acc;
            next_r.pc         = pcx.seq1;
            // A mapped write to the same pointer overrides its modify
            ptr.mod_en        = (r.mod != AMP_MOD_NONE);
          end

          AMP_OP_SET_BIT: begin
            // Read-modify-write of a single bit
            next_r.dmem_wr    = 1'b1;
            next_r.dmem_wdata = rdata | (8'h01 << r.bitn);
            ptr.wr_en         = 1'b1;
            ptr.wr_data       = rdata | (8'h01 << r.bitn);
            next_r.pc         = pcx.seq2;
          end

          AMP_OP_CLEAR_BIT: begin
            next_r.dmem_wr    = 1'b1;
            next_r.dmem_wdata = rdata & ~(8'h01 << r.bitn);
            ptr.wr_en         = 1'b1;
            ptr.wr_data       = rdata & ~(8'h01 << r.bitn);
            next_r.pc         = pcx.seq2;
          end

          AMP_OP_TEST_BIT: begin
            next_r.bit_true = rdata[r.bitn];
            next_r.pc       = pcx.seq2;
          end
          default: begin
            next_r.pc = pcx.seq1;
          end
        endcase
      end

      // Program strobe is on the pins this cycle
      AMP_S_PREQ: begin
        next_r.state = AMP_S_PGET;
      end

      // Program byte returned
      AMP_S_PGET: begin
        next_r.state = AMP_S_IDLE;
        next_r.ready = 1'b1;
        next_r.done  = 1'b1;
        unique case (r.op)
          AMP_OP_LOAD_IMM: begin
            next_r.acc = pmem_rdata;
            next_r.pc  = pcx.seq2;
          end

          AMP_OP_TABLE_LOAD: begin
            // Low byte was never overwritten, so restoring it is free
            next_r.acc = pmem_rdata;
            next_r.pc  = pcx.seq1;
          end

          AMP_OP_INDIRECT_JUMP: begin
            next_r.pc = {r.pc[14:8], pmem_rdata};
          end
          default: begin
            next_r.pc = pcx.seq1;
          end
        endcase
      end

      // Illegal one-hot code recovers to idle
      default: begin
        next_r.state = AMP_S_IDLE;
        next_r.ready = 1'b1;
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r            <= '0;
      r.state      <= AMP_S_IDLE;
      r.op         <= AMP_OP_NOP;
      r.mod        <= AMP_MOD_NONE;
      r.pc         <= AMP_PC_RST;
      r.acc        <= AMP_ACC_RST;
      r.ready      <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flops; top bit of the upper byte is unused
  assign cmd_ready      = r.ready;
  assign done           = r.done;
  assign bit_true       = r.bit_true;
  assign pc_upper_byte  = {1'b0, r.pc[14:8]};
  assign pc_lower_byte  = r.pc[7:0];
  assign acc            = r.acc;

  assign ptr_b          = ptr.b;
  assign ptr_x          = ptr.x;
  assign ptr_sp         = ptr.sp;

  assign dmem_addr      = r.dmem_addr;
  assign dmem_rd        = r.dmem_rd;
  assign dmem_wr        = r.dmem_wr;
  assign dmem_wdata     = r.dmem_wdata;
  assign dmem_reg_class = r.reg_class;

  assign pmem_addr      = r.pmem_addr;
  assign pmem_rd        = r.pmem_rd;

endmodule : amp_core

`default_nettype wire

/* File: amp_core_assertions.sv */
// Concurrent checks on the operand address and program counter block
`timescale 1ns/1ps
`default_nettype none

module amp_core_chk
  import amp_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Request side
  input wire logic        cmd_valid,
  input wire amp_op_t     cmd_op,
  input wire logic [7:0]  cmd_byte,
  input wire logic [14:0] cmd_word,
  input wire logic [5:0]  cmd_disp,
  input wire logic [3:0]  cmd_nibble,
  input wire logic        cmd_ptr_sel,
  input wire amp_mod_t    cmd_mod,
  input wire logic        cmd_ready,
  input wire logic        done,
  // State and memory side
  input wire logic [7:0]  pc_upper_byte,
  input wire logic [7:0]  pc_lower_byte,
  input wire logic [7:0]  acc,
  input wire logic [7:0]  ptr_b,
  input wire logic [7:0]  dmem_addr,
  input wire logic        dmem_rd,
  input wire logic        dmem_reg_class,
  input wire logic [14:0] pmem_addr,
  input wire logic        pmem_rd,
  input wire logic [7:0]  pmem_rdata
);
  // Accepted request, whole program counter, relative step
  wire        take   = cmd_valid && cmd_ready;
  wire [14:0] pc_now = {pc_upper_byte[6:0], pc_lower_byte};
  wire [14:0] step   = {{9{cmd_disp[5]}}, cmd_disp} + 15'h0001;
  // Ops that finish one cycle after acceptance
  wire        fast   = cmd_op inside {AMP_OP_NOP, AMP_OP_LOAD_B_SHORT, AMP_OP_RELATIVE_JUMP,
                                      AMP_OP_ABSOLUTE_JUMP, AMP_OP_LONG_JUMP};

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_fast_done: assert property (take && fast |=> done)
    else $error("one-cycle op late");
  chk_direct_addr: assert property (take && cmd_op == AMP_OP_LOAD_DIRECT
    |=> dmem_rd && dmem_addr == $past(cmd_byte)) else $error("direct address wrong");
  chk_ptr_incr: assert property (take && cmd_op == AMP_OP_LOAD_POINTER
    && !cmd_ptr_sel && cmd_mod == AMP_MOD_INC |-> ##3 ptr_b == $past(ptr_b, 3) + 8'h01)
    else $error("pointer increment wrong");
  chk_imm_addr: assert property (take && cmd_op == AMP_OP_LOAD_IMM
    |=> pmem_rd && pmem_addr == $past(pc_now) + 15'h0001) else $error("immediate fetch wrong");
  chk_short_load: assert property (take && cmd_op == AMP_OP_LOAD_B_SHORT
    |=> ptr_b == {AMP_SHORT_HI, $past(cmd_nibble)}) else $error("short load wrong");
  chk_table_addr: assert property (take && cmd_op inside {AMP_OP_TABLE_LOAD,
    AMP_OP_INDIRECT_JUMP} |=> pmem_rd && pmem_addr == {$past(pc_now[14:8]), $past(acc)})
    else $error("table pointer wrong");
  chk_table_data: assert property (take && cmd_op == AMP_OP_TABLE_LOAD |-> ##3
    (done && acc == $past(pmem_rdata) && pc_now == $past(pc_now, 3) + 15'h0001))
    else $error("table load result wrong");
  chk_ind_jump: assert property (take && cmd_op == AMP_OP_INDIRECT_JUMP |-> ##3
    (done && pc_upper_byte == $past(pc_upper_byte, 3) && pc_lower_byte == $past(pmem_rdata)))
    else $error("indirect jump wrong");
  chk_abs_jump: assert property (take && cmd_op == AMP_OP_ABSOLUTE_JUMP
    |=> pc_now == {$past(pc_now[14:12]), $past(cmd_word[11:0])}) else $error("jump wrong");
  chk_long_jump: assert property (take && cmd_op == AMP_OP_LONG_JUMP
    |=> pc_now == $past(cmd_word)) else $error("long jump wrong");
  chk_rel_jump: assert property (take && cmd_op == AMP_OP_RELATIVE_JUMP
    |=> pc_now == $past(pc_now) + $past(step)) else $error("relative jump wrong");
  chk_reg_class: assert property (dmem_rd
    |-> dmem_reg_class == (dmem_addr >= AMP_REG_CLASS)) else $error("register class flag wrong");

  // Main scenarios reached
  cover property (take && cmd_op == AMP_OP_TABLE_LOAD);
  cover property (take && cmd_op == AMP_OP_RELATIVE_JUMP && cmd_disp == 6'h1f);
  cover property (dmem_rd && dmem_reg_class);
endmodule : amp_core_chk

bind amp_core amp_core_chk chk_u (
  .clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_byte, .cmd_word, .cmd_disp, .cmd_nibble,
  .cmd_ptr_sel, .cmd_mod, .cmd_ready, .done, .pc_upper_byte, .pc_lower_byte, .acc, .ptr_b,
  .dmem_addr, .dmem_rd, .dmem_reg_class, .pmem_addr, .pmem_rd, .pmem_rdata);

`default_nettype wire

/* File: amp_core_tb.sv */
// Self-checking bench for the operand address and program counter block
`timescale 1ns/1ps
`default_nettype none

module amp_core_tb
  import amp_pkg::*;
;
  // Clock, reset and request
  logic        clk       = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        cmd_valid = 1'b0;
  logic [3:0]  cur_op    = 4'h0;  // Raw code, so unknown codes reach the design
  logic [31:0] cur_r     = 32'h0; // Random word sliced into the fields
  // Design outputs
  logic        cmd_ready, done, bit_true, dmem_rd, dmem_wr, dmem_reg_class, pmem_rd;
  logic [7:0]  pc_upper_byte, pc_lower_byte, acc, ptr_b, ptr_x, ptr_sp;
  logic [7:0]  dmem_addr, dmem_wdata, dmem_rdata, pmem_rdata;
  logic [14:0] pmem_addr;
  // Reference state and bookkeeping
  int          m_pc, m_acc, m_b, m_x, m_sp, m_bit;
  int          dm [256];
  int          n_errors, n_compared, cyc;
  logic [31:0] seed;
  logic [3:0]  op;
  // Directed cases: jumps at boundaries, pointer wrap, table ops, mapped writes
  logic [3:0]  d_op [14] = '{4'h9, 4'h8, 4'h7, 4'h7, 4'h7, 4'h5, 4'h2, 4'h2, 4'h6, 4'ha,
                             4'h4, 4'h3, 4'hb, 4'hd};
  logic [31:0] d_r  [14] = '{32'h004c7700, 32'h00012500, 32'h0f800000, 32'h10000000, 32'h0,
                             32'h0, 32'h80000000, 32'h40000000, 32'h0, 32'h0, 32'h0,
                             32'h40000000, 32'h050000fd, 32'h030000fe};

  // Clock at 250 MHz
  always #2 clk = ~clk;

  amp_core dut_u (
    .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(amp_op_t'(cur_op)),
    .cmd_byte(cur_r[7:0]), .cmd_word(cur_r[22:8]), .cmd_disp(cur_r[28:23]),
    .cmd_nibble(cur_r[3:0]), .cmd_ptr_sel(cur_r[29]),
    .cmd_mod(amp_mod_t'((cur_r[31:30] == 2'h3) ? 2'h0 : cur_r[31:30])),
    .cmd_bit(cur_r[26:24]), .cmd_ready(cmd_ready), .done(done), .bit_true(bit_true),
    .pc_upper_byte(pc_upper_byte), .pc_lower_byte(pc_lower_byte), .acc(acc), .ptr_b(ptr_b),
    .ptr_x(ptr_x), .ptr_sp(ptr_sp), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
    .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata), .dmem_reg_class(dmem_reg_class),
    .dmem_rdata(dmem_rdata), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
    .pmem_rdata(pmem_rdata));

  amp_mem_model mem_u (
    .clk(clk), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr),
    .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .pmem_addr(pmem_addr),
    .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata));

  // Stimulus source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr

  // Reference program bytes, same pattern the memory model holds
  function automatic int pm(input int a);
    return (a & 255) ^ ((a >> 8) & 127) ^ 'h5a;
  endfunction : pm

  // Data read; the three pointers shadow their mapped addresses
  function automatic int rd(input int a);
    return (a == 'hfc) ? m_x : (a == 'hfd) ? m_sp : (a == 'hfe) ? m_b : dm[a];
  endfunction : rd

  // Data write, also landing in a mapped pointer
  task automatic wr(input int a, input int v);
    dm[a] = v;
    case (a)
      'hfc: m_x = v;
      'hfd: m_sp = v;
      'hfe: m_b = v;
      default: ;
    endcase
  endtask : wr

  // Compare and count
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One request: predict, send, wait bounded for done, compare
  task automatic go(input logic [3:0] o, input logic [31:0] r);
    int pc, ap, v, f, n, lat;
    pc = m_pc;
    ap = r[29] ? m_x : m_b;
    f = int'(r[28:23]) - (r[28] ? 64 : 0);
    v = rd(r[7:0]);
    n = (r[31:30] == 2'h1) ? 1 : (r[31:30] == 2'h2) ? 255 : 0;
    lat = 3;
    m_pc = pc + 1;
    case (o)
      4'h1: begin
        m_acc = v;
        m_pc = pc + 2;
      end
      4'h2, 4'h3: begin
        v = rd(ap);
        if (o == 4'h3) wr(ap, m_acc);
        m_acc = v;
        // A write into the same pointer wins over its own post-modify
        if (o == 4'h3 && ap == (r[29] ? 'hfc : 'hfe)) n = 0;
        if (r[29]) m_x = (m_x + n) & 255;
        else m_b = (m_b + n) & 255;
      end
      4'h4: begin
        m_acc = pm(pc + 1);
        m_pc = pc + 2;
      end
      4'h5: begin
        m_b = r[3:0];
        lat = 1;
      end
      4'h6: m_acc = pm((pc & 'h7f00) | m_acc);
      4'h7: begin
        m_pc = pc + f + 1;
        lat = 1;
      end
      4'h8: begin
        m_pc = (pc & 'h7000) | r[19:8];
        lat = 1;
      end
      4'h9: begin
        m_pc = r[22:8];
        lat = 1;
      end
      4'ha: m_pc = (pc & 'h7f00) | pm((pc & 'h7f00) | m_acc);
      4'hb, 4'hc, 4'hd: begin
        if (o == 4'hb) wr(r[7:0], v | (1 << r[26:24]));
        if (o == 4'hc) wr(r[7:0], v & ~(1 << r[26:24]) & 255);
        m_bit = (v >> r[26:24]) & 1;
        m_pc = pc + 2;
      end
      default: lat = 1;
    endcase
    m_pc = m_pc & 'h7fff;
    @(posedge clk);
    cur_op <= o;
    cur_r <= r;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= (lat > 1);  // Refused while busy
    #1;
    if (o == 4'h1 || o > 4'ha) ap = r[7:0];
    if (o inside {[1:3], [11:13]}) check(dmem_reg_class, ap >= 'hf0);
    n = 1;
    while (done !== 1'b1 && n < 8) begin
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
      n++;
    end
    check(64'(n), 64'(lat));
    check({pc_upper_byte, pc_lower_byte, acc, ptr_b, ptr_x, ptr_sp}, {8'(m_pc >> 8), 8'(m_pc), 8'(m_acc), 8'(m_b), 8'(m_x), 8'(m_sp)});
    if (o == 4'hd) check(64'(bit_true), 64'(m_bit));
  endtask : go

  // Closing report
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Hang guard, well above the under two thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  // Main sequence
  initial begin
    for (int i = 0; i < 256; i++) begin
      dm[i] = i ^ 'h3c;
    end
    seed = 32'had46;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check({cmd_ready, done, pc_upper_byte, pc_lower_byte, acc, ptr_b, ptr_x, ptr_sp}, {1'b1, 49'h0});
    for (int i = 0; i < 14; i++) begin
      go(d_op[i], d_r[i]);
    end
    // Every code twice, unknown ones included, then random traffic
    for (int i = 0; i < 400; i++) begin
      seed = lfsr(seed);
      op = (i < 32) ? 4'(i) : seed[3:0];
      seed = lfsr(seed);
      go(op, seed);
    end
    complete_run();
  end
endmodule : amp_core_tb

`default_nettype wire

/* File: amp_if.sv */
// Interfaces between the sequencer and its pointer and target helpers
`timescale 1ns/1ps
`default_nettype none

// Pointer bank access
interface amp_ptr_if;
  logic       wr_en;     // Mapped data write
  logic [7:0] wr_addr;   // Its address
  logic [7:0] wr_data;   // Its data
  logic       short_en;  // Short immediate load of first pointer
  logic [3:0] short_val; // Nibble for it
  logic       mod_en;    // Post-modify request
  logic       mod_sel;   // 0 first pointer, 1 second pointer
  logic       mod_dec;   // 1 decrement, 0 increment
  logic [7:0] b;         // First pointer
  logic [7:0] x;         // Second pointer
  logic [7:0] sp;        // Stack pointer
  modport owner (input wr_en, wr_addr, wr_data, short_en, short_val, mod_en, mod_sel,
                 mod_dec, output b, x, sp);
  modport user  (output wr_en, wr_addr, wr_data, short_en, short_val, mod_en, mod_sel,
                 mod_dec, input b, x, sp);
endinterface : amp_ptr_if

// Program counter target arithmetic
interface amp_pc_if;
  logic [14:0] pc;       // Current program counter
  logic [5:0]  disp;     // Relative displacement field
  logic [14:0] word;     // Address word from instruction
  logic [7:0]  acc;      // Accumulator
  logic [14:0] seq1;     // Next after one byte
  logic [14:0] seq2;     // Next after two bytes
  logic [14:0] rel;      // Relative target
  logic [14:0] abs;      // Absolute target
  logic [14:0] tbl;      // Table pointer
  modport calc (input pc, disp, word, acc, output seq1, seq2, rel, abs, tbl);
  modport user (output pc, disp, word, acc, input seq1, seq2, rel, abs, tbl);
endinterface : amp_pc_if

`default_nettype wire

/* File: amp_mem_model.sv */
// Data and program memory model facing the block
`timescale 1ns/1ps
`default_nettype none

module amp_mem_model
  import amp_pkg::*;
(
  // Clock
  input wire logic        clk,
  // Data memory
  input wire logic [7:0]  dmem_addr,
  input wire logic        dmem_rd,
  input wire logic        dmem_wr,
  input wire logic [7:0]  dmem_wdata,
  output var logic [7:0]  dmem_rdata,
  // Program memory
  input wire logic [14:0] pmem_addr,
  input wire logic        pmem_rd,
  output var logic [7:0]  pmem_rdata
);
  logic [7:0] mem [256]; // Data bytes, seeded with a known pattern

  // Program contents are a pure function of the address
  function automatic logic [7:0] rom(input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h5a;
  endfunction : rom

  // Seed memory and buses
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h3c;
    end
    dmem_rdata = 8'h00;
    pmem_rdata = 8'h00;
  end

  // Data lands the cycle after a strobe; idle buses flip so stale data never matches
  always @(posedge clk) begin
    if (dmem_wr) begin
      mem[dmem_addr] <= dmem_wdata;
    end
    dmem_rdata <= dmem_rd ? mem[dmem_addr] : ~dmem_rdata;
    pmem_rdata <= pmem_rd ? rom(pmem_addr) : ~pmem_rdata;
  end
endmodule : amp_mem_model

`default_nettype wire

/* File: amp_pc_calc.sv */
// Program counter target arithmetic, no state
`timescale 1ns/1ps
`default_nettype none

module amp_pc_calc
  import amp_pkg::*;
(
  // Sequencer side
  amp_pc_if.calc cif
);

  // Field holds distance minus one, so -32..31 covers -31..+32
  assign cif.rel  = cif.pc + {{9{cif.disp[5]}}, cif.disp} + AMP_LEN1;
  // Upper three bits kept: target stays in the current 4 kbyte page
  assign cif.abs  = {cif.pc[14:12], cif.word[11:0]};
  // Accumulator stands in for the low byte while reading the table
  assign cif.tbl  = {cif.pc[14:8], cif.acc};
  // Sequential successors
  assign cif.seq1 = cif.pc + AMP_LEN1;
  assign cif.seq2 = cif.pc + AMP_LEN2;

endmodule : amp_pc_calc

`default_nettype wire

/* File: amp_pkg.sv */
// Shared constants and types for the operand address and program counter block
package amp_pkg;

  // Widths
  localparam int AMP_PC_W   = 15;
  localparam int AMP_DATA_W = 8;

  // Mapped pointer addresses and register class base
  localparam logic [7:0] AMP_ADDR_X    = 8'hfc;
  localparam logic [7:0] AMP_ADDR_SP   = 8'hfd;
  localparam logic [7:0] AMP_ADDR_B    = 8'hfe;
  localparam logic [7:0] AMP_REG_CLASS = 8'hf0;

  // Reset values
  localparam logic [7:0]  AMP_PTR_RST = 8'h00;
  localparam logic [7:0]  AMP_ACC_RST = 8'h00;
  localparam logic [14:0] AMP_PC_RST  = 15'h0000;

  // Short load clears the high nibble to this value
  localparam logic [3:0] AMP_SHORT_HI = 4'h0;

  // Instruction lengths in bytes, added to the program counter
  localparam logic [14:0] AMP_LEN1 = 15'h0001;
  localparam logic [14:0] AMP_LEN2 = 15'h0002;

  // Decoded operations handed to the block
  typedef enum logic [3:0] {
    AMP_OP_NOP           = 4'h0,
    AMP_OP_LOAD_DIRECT   = 4'h1,
    AMP_OP_LOAD_POINTER  = 4'h2,
    AMP_OP_XCHG_POINTER  = 4'h3,
    AMP_OP_LOAD_IMM      = 4'h4,
    AMP_OP_LOAD_B_SHORT  = 4'h5,
    AMP_OP_TABLE_LOAD    = 4'h6,
    AMP_OP_RELATIVE_JUMP = 4'h7,
    AMP_OP_ABSOLUTE_JUMP = 4'h8,
    AMP_OP_LONG_JUMP     = 4'h9,
    AMP_OP_INDIRECT_JUMP = 4'ha,
    AMP_OP_SET_BIT       = 4'hb,
    AMP_OP_CLEAR_BIT     = 4'hc,
    AMP_OP_TEST_BIT      = 4'hd
  } amp_op_t;

  // Pointer post-modify choice
  typedef enum logic [1:0] {
    AMP_MOD_NONE = 2'h0,
    AMP_MOD_INC  = 2'h1,
    AMP_MOD_DEC  = 2'h2
  } amp_mod_t;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    AMP_S_IDLE = 5'b00001,
    AMP_S_DREQ = 5'b00010,
    AMP_S_DGET = 5'b00100,
    AMP_S_PREQ = 5'b01000,
    AMP_S_PGET = 5'b10000
  } amp_state_t;

endpackage : amp_pkg

/* File: amp_ptr_bank.sv */
// Pointer bank: first pointer, second pointer and stack pointer
`timescale 1ns/1ps
`default_nettype none

module amp_ptr_bank
  import amp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Sequencer side
  amp_ptr_if.owner pif
);

  // All pointer state
  typedef struct packed {
    logic [7:0] b;
    logic [7:0] x;
    logic [7:0] sp;
  } amp_ptr_st_t;

  amp_ptr_st_t r;       // Registered pointers
  amp_ptr_st_t next_r;  // Next value

  // Modify first, then short load, then mapped write, so a write wins
  always_comb begin
    next_r = r;
    if (pif.mod_en) begin
      // 8-bit add wraps on its own; no flag is touched
      if (pif.mod_sel) begin
        next_r.x = pif.mod_dec ? r.x - 8'h01 : r.x + 8'h01;
      end else begin
        next_r.b = pif.mod_dec ? r.b - 8'h01 : r.b + 8'h01;
      end
    end
    if (pif.short_en) begin
      next_r.b = {AMP_SHORT_HI, pif.short_val};
    end
    if (pif.wr_en) begin
      // Pointers live in data space like any register
      unique case (pif.wr_addr)
        AMP_ADDR_X:  next_r.x  = pif.wr_data;
        AMP_ADDR_SP: next_r.sp = pif.wr_data;
        AMP_ADDR_B:  next_r.b  = pif.wr_data;
        default:     next_r    = next_r;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '{b: AMP_PTR_RST, x: AMP_PTR_RST, sp: AMP_PTR_RST};
    end else begin
      r <= next_r;
    end
  end

  // Pointer values straight from flops
  assign pif.b  = r.b;
  assign pif.x  = r.x;
  assign pif.sp = r.sp;

endmodule : amp_ptr_bank

`default_nettype wire
